/* File: qpw_pkg.sv */
// constants, opcodes and state codes shared by the wiper controller files
// assumes a single clock domain on the core side; pins are synchronised
package qpw_pkg;

    // potentiometer array geometry
    localparam int NUM_POTS = 4;
    localparam int NV_PER_POT = 4;
    localparam int TAP_W = 8;
    localparam logic [7:0] TAP_MAX = 8'hFF;
    localparam logic [7:0] TAP_MIN = 8'h00;
    localparam logic [1:0] DEFAULT_STORE = 2'h0;

    // power-on content of every nonvolatile data register
    localparam logic [7:0] NV_RESET = 8'h80;

    // fixed upper five bits of the slave address (value is arbitrary)
    localparam logic [4:0] DEV_ID = 5'h0A;

    // instruction byte layout
    localparam int OPC_MSB = 7;
    localparam int OPC_LSB = 4;
    localparam int POT_MSB = 3;
    localparam int POT_LSB = 2;
    localparam int REG_MSB = 1;
    localparam int REG_LSB = 0;

    // instruction opcodes
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_NV = 4'hB;
    localparam logic [3:0] OP_WR_NV = 4'hC;
    localparam logic [3:0] OP_NV_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_WIPER_TO_NV = 4'hE;

    // bit counter end value within a byte
    localparam logic [2:0] BIT_LAST = 3'h7;

    // positions of the pins in the synchroniser vector
    localparam int PIN_W = 10;
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_CS = 2;
    localparam int PIN_DIR = 3;
    localparam int PIN_SEL_LO = 4;
    localparam int PIN_SEL_HI = 5;
    localparam int PIN_WP = 6;
    localparam int PIN_ADDR_LSB = 7;
    localparam int PIN_ADDR_MSB = 9;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'h0,
        BUS_ADDR = 4'h1,
        BUS_ADDR_ACK = 4'h2,
        BUS_INSTR = 4'h3,
        BUS_INSTR_ACK = 4'h4,
        BUS_WDATA = 4'h5,
        BUS_WDATA_ACK = 4'h6,
        BUS_RDATA = 4'h7,
        BUS_RDATA_ACK = 4'h8
    } qpw_bus_state_type;

endpackage

/* File: qpw_sync.sv */
// two flip-flop synchroniser for a vector of independent pin levels
// assumes each bit is a slow level or is edge-detected downstream
`timescale 1ns/1ps

module qpw_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } qpw_sync_state_type;

    qpw_sync_state_type state_ff;
    qpw_sync_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.meta = d;
        nxt_state.stable = state_ff.meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // the edge-detected pins idle high; zeros would fake a cs rise
            state_ff <= '1;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    assign q = state_ff.stable;

endmodule

/* File: qpw_step.sv */
// saturating one-tap step of a wiper position
// pure combinational; the caller registers the result
`timescale 1ns/1ps

module qpw_step (
    // current tap and direction
    input wire logic [7:0] tap,
    input wire logic up,
    // stepped tap
    output logic [7:0] nxt_tap
);

    always_comb begin
        nxt_tap = tap;
        if (up && tap != qpw_pkg::TAP_MAX) begin
            nxt_tap = tap + 8'h01;
        end else if (!up && tap != qpw_pkg::TAP_MIN) begin
            nxt_tap = tap - 8'h01;
        end
    end

endmodule

/* File: qpw_core.sv */
// wiper controller for four potentiometers: 2-wire slave, up/down stepper,
// nonvolatile data registers with write protect and power-on recall
// assumes all pins are asynchronous to clk and scl is far slower than clk
//
// Functional notes
// - bits sampled on rising serial clock, read data driven after falling.
// - data line is open drain: pull low or release only.
// - address pins give the low three bits of the 8-bit slave address.
// - a transfer whose slave address mismatches the pins is ignored.
// - chip select low: serial clock steps the selected pot, direction pin.
// - 2-wire bus ignored while chip select low, active while high.
// - one serial clock input clocks both the bus and the stepper.
// - two select pins choose which of four pots is stepped.
// - write protect low blocks every nonvolatile write, bus or store.
// - each pot has one wiper register and four nonvolatile registers.
// - wiper outputs follow the wiper registers directly.
// - wiper register is an 8-bit tap index, 256 taps.
// - after power-up the default store is copied into each wiper.
// - bus master may write and read wiper and nonvolatile registers.
// - bus supports write, read and transfer between data and wiper.
`timescale 1ns/1ps

module qpw_core (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // 2-wire bus
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_drive_n,
    // up/down interface
    input wire logic cs,
    input wire logic up_dn,
    input wire logic pot_select_lo,
    input wire logic pot_select_hi,
    // configuration pins
    input wire logic wp_n,
    input wire logic bus_addr_pin_bit0,
    input wire logic bus_addr_pin_bit1,
    input wire logic bus_addr_pin_bit2,
    // wiper switch selection
    output logic [7:0] wiper_tap0,
    output logic [7:0] wiper_tap1,
    output logic [7:0] wiper_tap2,
    output logic [7:0] wiper_tap3,
    // status
    output logic nv_write_reject
);

    typedef struct packed {
        logic scl_prev;
        logic sda_prev;
        logic cs_prev;
        qpw_pkg::qpw_bus_state_type st;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] instr;
        logic sda_drive_n;
        logic sda_out;
        logic recalled;
        logic nv_reject;
        logic [3:0][7:0] wiper;
        logic [15:0][7:0] nv;
    } qpw_core_state_type;

    // idle lines sit high, so the previous samples start high to avoid
    // a false edge or a false store right after reset
    localparam qpw_core_state_type RESET_STATE = '{
        scl_prev: 1'b1,
        sda_prev: 1'b1,
        cs_prev: 1'b1,
        st: qpw_pkg::BUS_IDLE,
        bit_cnt: 3'h0,
        shift: 8'h00,
        instr: 8'h00,
        sda_drive_n: 1'b1,
        sda_out: 1'b0,
        recalled: 1'b0,
        nv_reject: 1'b0,
        wiper: {4{qpw_pkg::NV_RESET}},
        nv: {16{qpw_pkg::NV_RESET}}
    };

    function automatic logic [3:0] nv_index(input logic [1:0] pot,
                                            input logic [1:0] sel);
        nv_index = {pot, sel};
    endfunction

    function automatic logic [3:0] op_of(input logic [7:0] b);
        op_of = b[qpw_pkg::OPC_MSB:qpw_pkg::OPC_LSB];
    endfunction

    function automatic logic [1:0] pot_of(input logic [7:0] b);
        pot_of = b[qpw_pkg::POT_MSB:qpw_pkg::POT_LSB];
    endfunction

    function automatic logic [1:0] reg_of(input logic [7:0] b);
        reg_of = b[qpw_pkg::REG_MSB:qpw_pkg::REG_LSB];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    qpw_core_state_type state_ff;
    qpw_core_state_type nxt_state;
    logic [qpw_pkg::PIN_W-1:0] pins_raw;
    logic [qpw_pkg::PIN_W-1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic cs_s;
    logic dir_s;
    logic wp_s;
    logic [1:0] sel_s;
    logic [2:0] addr_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] step_tap;
    logic [7:0] rx_byte;

    assign pins_raw = {bus_addr_pin_bit2, bus_addr_pin_bit1,
                       bus_addr_pin_bit0, wp_n, pot_select_hi,
                       pot_select_lo, up_dn, cs, sda_in, scl};

    qpw_sync #(
        .W(qpw_pkg::PIN_W)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .d(pins_raw),
        .q(pins_s)
    );

    assign scl_s = pins_s[qpw_pkg::PIN_SCL];
    assign sda_s = pins_s[qpw_pkg::PIN_SDA];
    assign cs_s = pins_s[qpw_pkg::PIN_CS];
    assign dir_s = pins_s[qpw_pkg::PIN_DIR];
    assign wp_s = pins_s[qpw_pkg::PIN_WP];
    assign sel_s = {pins_s[qpw_pkg::PIN_SEL_HI], pins_s[qpw_pkg::PIN_SEL_LO]};
    assign addr_s = pins_s[qpw_pkg::PIN_ADDR_MSB:qpw_pkg::PIN_ADDR_LSB];

    // one scl input serves both interfaces; cs picks the meaning
    assign scl_rise = scl_s & ~state_ff.scl_prev;
    assign scl_fall = ~scl_s & state_ff.scl_prev;
    assign bus_start = scl_s & state_ff.scl_prev & ~sda_s & state_ff.sda_prev;
    assign bus_stop = scl_s & state_ff.scl_prev & sda_s & ~state_ff.sda_prev;
    assign rx_byte = {state_ff.shift[6:0], sda_s};

    qpw_step u_step (
        .tap(state_ff.wiper[sel_s]),
        .up(dir_s),
        .nxt_tap(step_tap)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_state = state_ff;
        nxt_state.scl_prev = scl_s;
        nxt_state.sda_prev = sda_s;
        nxt_state.cs_prev = cs_s;
        nxt_state.nv_reject = 1'b0;
        nxt_state.sda_out = 1'b0;
        if (!state_ff.recalled) begin
            // first enabled cycle after reset loads every default store
            for (int p = 0; p < qpw_pkg::NUM_POTS; p++) begin
                nxt_state.wiper[p] =
                    state_ff.nv[nv_index(2'(p), qpw_pkg::DEFAULT_STORE)];
            end
            nxt_state.recalled = 1'b1;
        end else if (!cs_s) begin
            nxt_state.st = qpw_pkg::BUS_IDLE;
            nxt_state.sda_drive_n = 1'b1;
            if (scl_rise) begin
                nxt_state.wiper[sel_s] = step_tap;
            end
        end else if (!state_ff.cs_prev) begin
            // cs released with scl high stores the selected wiper
            nxt_state.st = qpw_pkg::BUS_IDLE;
            if (scl_s) begin
                if (wp_s) begin
                    nxt_state.nv[nv_index(sel_s, qpw_pkg::DEFAULT_STORE)] =
                        state_ff.wiper[sel_s];
                end else begin
                    nxt_state.nv_reject = 1'b1;
                end
            end
        end else if (bus_start) begin
            nxt_state.st = qpw_pkg::BUS_ADDR;
            nxt_state.bit_cnt = 3'h0;
            nxt_state.sda_drive_n = 1'b1;
        end else if (bus_stop) begin
            nxt_state.st = qpw_pkg::BUS_IDLE;
            nxt_state.sda_drive_n = 1'b1;
        end else if (scl_rise) begin
            unique case (state_ff.st)
                qpw_pkg::BUS_ADDR, qpw_pkg::BUS_INSTR,
                qpw_pkg::BUS_WDATA: begin
                    nxt_state.shift = rx_byte;
                    nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
                end
                qpw_pkg::BUS_RDATA_ACK: begin
                    nxt_state.st = qpw_pkg::BUS_IDLE;
                end
                qpw_pkg::BUS_IDLE, qpw_pkg::BUS_ADDR_ACK,
                qpw_pkg::BUS_INSTR_ACK, qpw_pkg::BUS_WDATA_ACK,
                qpw_pkg::BUS_RDATA: begin
                end
            endcase
            if (state_ff.bit_cnt == qpw_pkg::BIT_LAST) begin
                unique case (state_ff.st)
                    qpw_pkg::BUS_ADDR: begin
                        if (rx_byte == {qpw_pkg::DEV_ID, addr_s}) begin
                            nxt_state.st = qpw_pkg::BUS_ADDR_ACK;
                        end else begin
                            nxt_state.st = qpw_pkg::BUS_IDLE;
                        end
                    end
                    qpw_pkg::BUS_INSTR: begin
                        nxt_state.instr = rx_byte;
                        nxt_state.st = qpw_pkg::BUS_INSTR_ACK;
                        unique case (op_of(rx_byte))
                            qpw_pkg::OP_RD_WIPER: begin
                                nxt_state.shift =
                                    state_ff.wiper[pot_of(rx_byte)];
                            end
                            qpw_pkg::OP_RD_NV: begin
                                nxt_state.shift = state_ff.nv[nv_index(
                                    pot_of(rx_byte), reg_of(rx_byte))];
                            end
                            qpw_pkg::OP_NV_TO_WIPER: begin
                                nxt_state.wiper[pot_of(rx_byte)] =
                                    state_ff.nv[nv_index(pot_of(rx_byte),
                                    reg_of(rx_byte))];
                            end
                            qpw_pkg::OP_WIPER_TO_NV: begin
                                if (wp_s) begin
                                    nxt_state.nv[nv_index(pot_of(rx_byte),
                                        reg_of(rx_byte))] =
                                        state_ff.wiper[pot_of(rx_byte)];
                                end else begin
                                    nxt_state.nv_reject = 1'b1;
                                end
                            end
                            qpw_pkg::OP_WR_WIPER, qpw_pkg::OP_WR_NV: begin
                            end
                            default: begin
                                // unknown opcode: no acknowledge
                                nxt_state.st = qpw_pkg::BUS_IDLE;
                            end
                        endcase
                    end
                    qpw_pkg::BUS_WDATA: begin
                        nxt_state.st = qpw_pkg::BUS_WDATA_ACK;
                        if (op_of(state_ff.instr) == qpw_pkg::OP_WR_WIPER) begin
                            nxt_state.wiper[pot_of(state_ff.instr)] =
                                rx_byte;
                        end else if (wp_s) begin
                            nxt_state.nv[nv_index(pot_of(state_ff.instr),
                                reg_of(state_ff.instr))] = rx_byte;
                        end else begin
                            nxt_state.nv_reject = 1'b1;
                        end
                    end
                    qpw_pkg::BUS_IDLE, qpw_pkg::BUS_ADDR_ACK,
                    qpw_pkg::BUS_INSTR_ACK, qpw_pkg::BUS_WDATA_ACK,
                    qpw_pkg::BUS_RDATA, qpw_pkg::BUS_RDATA_ACK: begin
                    end
                endcase
            end
        end else if (scl_fall) begin
            // all line changes happen after a falling edge
            unique case (state_ff.st)
                qpw_pkg::BUS_ADDR_ACK, qpw_pkg::BUS_INSTR_ACK,
                qpw_pkg::BUS_WDATA_ACK: begin
                    if (state_ff.sda_drive_n) begin
                        nxt_state.sda_drive_n = 1'b0;
                    end else begin
                        nxt_state.sda_drive_n = 1'b1;
                        nxt_state.bit_cnt = 3'h0;
                        nxt_state.st = qpw_pkg::BUS_IDLE;
                        if (state_ff.st == qpw_pkg::BUS_ADDR_ACK) begin
                            nxt_state.st = qpw_pkg::BUS_INSTR;
                        end else if (state_ff.st == qpw_pkg::BUS_INSTR_ACK)
                        begin
                            unique case (op_of(state_ff.instr))
                                qpw_pkg::OP_RD_WIPER, qpw_pkg::OP_RD_NV:
                                begin
                                    nxt_state.st = qpw_pkg::BUS_RDATA;
                                    nxt_state.sda_drive_n = state_ff.shift[7];
                                end
                                qpw_pkg::OP_WR_WIPER, qpw_pkg::OP_WR_NV:
                                begin
                                    nxt_state.st = qpw_pkg::BUS_WDATA;
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                qpw_pkg::BUS_RDATA: begin
                    if (state_ff.bit_cnt == qpw_pkg::BIT_LAST) begin
                        nxt_state.sda_drive_n = 1'b1;
                        nxt_state.st = qpw_pkg::BUS_RDATA_ACK;
                    end else begin
                        // a one bit releases the line, a zero pulls it low
                        nxt_state.sda_drive_n = state_ff.shift[6];
                        nxt_state.shift = {state_ff.shift[6:0], 1'b0};
                        nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
                    end
                end
                qpw_pkg::BUS_IDLE, qpw_pkg::BUS_ADDR, qpw_pkg::BUS_INSTR,
                qpw_pkg::BUS_WDATA, qpw_pkg::BUS_RDATA_ACK: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= RESET_STATE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign sda_out = state_ff.sda_out;
    assign sda_drive_n = state_ff.sda_drive_n;
    assign wiper_tap0 = state_ff.wiper[0];
    assign wiper_tap1 = state_ff.wiper[1];
    assign wiper_tap2 = state_ff.wiper[2];
    assign wiper_tap3 = state_ff.wiper[3];
    assign nv_write_reject = state_ff.nv_reject;

endmodule

/* File: qpw_core_sva.sv */
// port assertions for the wiper controller
// assumes pins move just after clk edges; ce drops only when idle
`timescale 1ns/1ps

module qpw_core_sva (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pins
    input wire logic scl,
    input wire logic cs,
    input wire logic wp_n,
    // outputs
    input wire logic sda_out,
    input wire logic sda_drive_n,
    input wire logic [7:0] wiper_tap0,
    input wire logic [7:0] wiper_tap1,
    input wire logic [7:0] wiper_tap2,
    input wire logic [7:0] wiper_tap3,
    input wire logic nv_write_reject
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////
    // a pin change reaches an output three edges later (two sync flops)
    property p_od; !sda_out; endproperty
    a_od: assert property (p_od) else $error("sda_out high");
    property p_cs_rel; (!cs) [*4] |-> sda_drive_n; endproperty
    a_cs_rel: assert property (p_cs_rel)
        else $error("line held while cs low");
    sequence s_step; (!cs) [*5] ##0 $changed(wiper_tap0); endsequence
    // nine bits so that a wrap from 255 to 0 is not one tap
    property p_one_tap;
        s_step |-> {1'h0, wiper_tap0} + 9'h001 == {1'h0, $past(wiper_tap0)}
            || {1'h0, $past(wiper_tap0)} + 9'h001 == {1'h0, wiper_tap0};
    endproperty
    a_one_tap: assert property (p_one_tap)
        else $error("step not one tap");
    property p_step_when;
        s_step |-> $past(scl, 3) && !$past(scl, 4);
    endproperty
    a_step_when: assert property (p_step_when)
        else $error("step without clock rise");
    property p_ack_when;
        $changed(sda_drive_n) |-> !$past(scl, 3) && $past(scl, 4);
    endproperty
    a_ack_when: assert property (p_ack_when)
        else $error("data line moved off clock fall");
    property p_rej_wp; nv_write_reject |-> !$past(wp_n, 3); endproperty
    a_rej_wp: assert property (p_rej_wp)
        else $error("reject with protect off");
    property p_rej_once; nv_write_reject |=> !nv_write_reject; endproperty
    a_rej_once: assert property (p_rej_once)
        else $error("reject longer than a cycle");
    property p_recall;
        $rose(reset_n) |-> (wiper_tap0 == qpw_pkg::NV_RESET
            && wiper_tap1 == qpw_pkg::NV_RESET
            && wiper_tap2 == qpw_pkg::NV_RESET
            && wiper_tap3 == qpw_pkg::NV_RESET) [*2];
    endproperty
    a_recall: assert property (p_recall)
        else $error("wiper not recalled");
    c_step: cover property (s_step);
    c_rej: cover property (nv_write_reject);
    c_ack: cover property ($fell(sda_drive_n));
endmodule

bind qpw_core qpw_core_sva u_sva (.clk, .reset_n, .scl, .cs, .wp_n, .sda_out,
    .sda_drive_n, .wiper_tap0, .wiper_tap1, .wiper_tap2, .wiper_tap3,
    .nv_write_reject);

/* File: qpw_master.sv */
// partner model: 2-wire bus master and up/down pin controller
// assumes clk is the core clock; pins change just after its rising edge
`timescale 1ns/1ps

module qpw_master (
    // clock and wire level
    input wire logic clk,
    input wire logic sda_w,
    // bus pins, data is released high
    output logic scl,
    output logic sda_m,
    // up/down pins
    output logic cs,
    output logic up_dn,
    output logic s_lo,
    output logic s_hi
);
    initial begin
        scl = 1'h1;
        sda_m = 1'h1;
        cs = 1'h1;
        up_dn = 1'h0;
        s_lo = 1'h0;
        s_hi = 1'h0;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask

    ////////////////////////////////////////
    // 200 ns clock period; data moves mid-low, read late in the high phase
    task automatic bt(input logic b, output logic r);
        sda_m <= b;
        tk(2);
        scl <= 1'h1;
        tk(4);
        r = sda_w;
        scl <= 1'h0;
        tk(2);
    endtask

    task automatic by(input logic [7:0] d, output logic [7:0] r,
        output logic k);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bt(d[i], r[i]);
        end
        bt(1'h1, a);
        k = !a;
    endtask

    // one operation; the clock stands high outside the frame
    task automatic op(input logic [7:0] a, i, d, input logic nd,
        output logic [7:0] r, output logic [2:0] k);
        logic [7:0] x;
        k = 3'h0;
        r = 8'h00;
        sda_m <= 1'h0;
        tk(4);
        scl <= 1'h0;
        tk(2);
        by(a, x, k[2]);
        by(i, x, k[1]);
        if (nd) begin
            by(d, r, k[0]);
        end
        sda_m <= 1'h0;
        tk(2);
        scl <= 1'h1;
        tk(4);
        sda_m <= 1'h1;
        tk(4);
    endtask

    task automatic step(input logic [1:0] p, input logic u, input int n);
        cs <= 1'h0;
        s_hi <= p[1];
        s_lo <= p[0];
        up_dn <= u;
        repeat (n) begin
            tk(4);
            scl <= 1'h0;
            tk(4);
            scl <= 1'h1;
        end
        tk(4);
        scl <= 1'h0;
        tk(4);
        cs <= 1'h1; // clock low here, so leaving is no store
        tk(4);
        scl <= 1'h1;
        tk(4);
    endtask

    task automatic store(input logic [1:0] p);
        s_hi <= p[1];
        s_lo <= p[0];
        cs <= 1'h0;
        tk(4);
        cs <= 1'h1;
        tk(8);
    endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the wiper controller with a pin-level partner
// assumes the partner model and checker are compiled first
`timescale 1ns/1ps

module tb_top;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic wp_n, a0, a1, a2, ce;
    logic scl, sda_m, cs, up_dn, s_lo, s_hi, sda_out, sda_drive_n, rej;
    logic sda_w;
    logic [7:0] t0, t1, t2, t3, q;
    logic [7:0] tp [4];
    int failures = 0;
    int n_tests = 0;
    int n_rej = 0;

    always #12.5 clk = ~clk;
    // pull-up: the wire is low while either party pulls it
    assign sda_w = sda_m & (sda_drive_n | sda_out);
    always_comb tp = '{t0, t1, t2, t3};
    always @(posedge clk) begin
        if (rej === 1'h1) n_rej++;
    end

    qpw_master u_m (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m),
        .cs(cs), .up_dn(up_dn), .s_lo(s_lo), .s_hi(s_hi));
    qpw_core dut_u (.clk(clk), .reset_n(reset_n), .ce(ce), .scl(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
        .cs(cs), .up_dn(up_dn), .pot_select_lo(s_lo), .pot_select_hi(s_hi),
        .wp_n(wp_n), .bus_addr_pin_bit0(a0), .bus_addr_pin_bit1(a1),
        .bus_addr_pin_bit2(a2), .wiper_tap0(t0), .wiper_tap1(t1),
        .wiper_tap2(t2), .wiper_tap3(t3), .nv_write_reject(rej));

    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, s);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic bop(input logic [3:0] o, input logic [1:0] p, r,
        input logic [7:0] d, input logic nd, input logic [2:0] ek);
        logic [2:0] k;
        u_m.op({qpw_pkg::DEV_ID, a2, a1, a0}, {o, p, r}, d, nd, q, k);
        chk("ack", {5'h00, ek}, {5'h00, k});
    endtask

    task automatic t_power;
        for (int i = 0; i < 4; i++) begin
            chk("tap", qpw_pkg::NV_RESET, tp[i]);
        end
        chk("release", 8'h01, {7'h00, sda_drive_n});
        $display("done power");
    endtask

    task automatic t_step;
        u_m.step(2'h0, 1'h1, 3);
        chk("up", qpw_pkg::NV_RESET + 8'h03, t0);
        u_m.step(2'h0, 1'h0, 5);
        chk("down", qpw_pkg::NV_RESET - 8'h02, t0);
        for (int p = 1; p < 4; p++) begin
            u_m.step(p[1:0], 1'h1, p);
            chk("sel", qpw_pkg::NV_RESET + 8'(p), tp[p]);
            chk("other", 8'h7E, t0);
        end
        $display("done step");
    endtask

    task automatic t_bus;
        bop(qpw_pkg::OP_WR_WIPER, 2'h2, 2'h0, 8'h5A, 1'h1, 3'h7);
        chk("wiper", 8'h5A, t2);
        bop(qpw_pkg::OP_RD_WIPER, 2'h2, 2'h0, 8'hFF, 1'h1, 3'h6);
        chk("rd wiper", 8'h5A, q);
        bop(qpw_pkg::OP_WR_NV, 2'h1, 2'h2, 8'h3C, 1'h1, 3'h7);
        bop(qpw_pkg::OP_RD_NV, 2'h1, 2'h2, 8'hFF, 1'h1, 3'h6);
        chk("rd nv", 8'h3C, q);
        chk("wiper kept", 8'h81, t1);
        bop(qpw_pkg::OP_NV_TO_WIPER, 2'h1, 2'h2, 8'h00, 1'h0, 3'h6);
        chk("nv to wiper", 8'h3C, t1);
        bop(qpw_pkg::OP_WIPER_TO_NV, 2'h2, 2'h3, 8'h00, 1'h0, 3'h6);
        bop(qpw_pkg::OP_RD_NV, 2'h2, 2'h3, 8'hFF, 1'h1, 3'h6);
        chk("wiper to nv", 8'h5A, q);
        $display("done bus");
    endtask

    task automatic t_ce;
        ce <= 1'h0;
        u_m.step(2'h1, 1'h1, 2);
        ce <= 1'h1;
        u_m.tk(4);
        chk("frozen", 8'h3C, t1);
        $display("done freeze");
    endtask

    task automatic t_sat;
        bop(qpw_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'hFE, 1'h1, 3'h7);
        u_m.step(2'h0, 1'h1, 3);
        chk("top", qpw_pkg::TAP_MAX, t0);
        bop(qpw_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'h01, 1'h1, 3'h7);
        u_m.step(2'h0, 1'h0, 3);
        chk("bottom", qpw_pkg::TAP_MIN, t0);
        $display("done saturate");
    endtask

    task automatic t_addr;
        logic [2:0] k;
        u_m.op({qpw_pkg::DEV_ID, ~a2, a1, a0},
            {qpw_pkg::OP_WR_WIPER, 2'h3, 2'h0}, 8'h99, 1'h1, q, k);
        chk("nak", 8'h00, {5'h00, k});
        chk("kept", 8'h83, t3);
        a2 <= 1'h1;
        a0 <= 1'h1;
        u_m.tk(4);
        bop(qpw_pkg::OP_WR_WIPER, 2'h3, 2'h0, 8'h44, 1'h1, 3'h7);
        chk("new addr", 8'h44, t3);
        bop(4'hF, 2'h3, 2'h0, 8'h00, 1'h0, 3'h4);
        $display("done address");
    endtask

    task automatic t_wp;
        int r0;
        wp_n <= 1'h0;
        u_m.tk(4);
        r0 = n_rej;
        bop(qpw_pkg::OP_WR_NV, 2'h0, 2'h3, 8'h11, 1'h1, 3'h7);
        bop(qpw_pkg::OP_RD_NV, 2'h0, 2'h3, 8'hFF, 1'h1, 3'h6);
        chk("nv kept", qpw_pkg::NV_RESET, q);
        u_m.store(2'h0);
        chk("rejects", 8'(r0 + 2), 8'(n_rej));
        bop(qpw_pkg::OP_NV_TO_WIPER, 2'h0, 2'h0, 8'h00, 1'h0, 3'h6);
        chk("no store", qpw_pkg::NV_RESET, t0);
        wp_n <= 1'h1;
        u_m.tk(4);
        u_m.step(2'h0, 1'h1, 2);
        u_m.store(2'h0);
        bop(qpw_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'h00, 1'h1, 3'h7);
        bop(qpw_pkg::OP_NV_TO_WIPER, 2'h0, 2'h0, 8'h00, 1'h0, 3'h6);
        chk("store", 8'h82, t0);
        $display("done protect");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        {ce, wp_n, a2, a1, a0} <= 5'h1A;
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        u_m.tk(6);
        t_power();
        t_step();
        t_bus();
        t_ce();
        t_sat();
        t_addr();
        t_wp();
        give_verdict();
    end

    // about 4000 cycles are expected; this is a generous bound
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule
